/* ssap_pkg.sv */
/*
 * Package for the secure slot access policy block: configuration byte
 * offsets, field positions in the slot policy word, reset values and
 * the command and zone enumerations.
 * Assumes byte addressing of the configuration zone, 8-bit register data.
 */
package ssap_pkg;

	// Register bus geometry
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;

	// Printed byte offsets of the configuration bytes held here
	localparam logic [6:0] CFG_BASE = 7'h14;
	localparam logic [6:0] POLICY_OFS = 7'h14;
	localparam logic [6:0] USES_OFS = 7'h34;
	localparam logic [6:0] DERIVE_OFS = 7'h35;
	localparam logic [6:0] MAP_OFS = 7'h44;
	localparam logic [6:0] MAP_END = 7'h53;
	localparam logic [6:0] USER_OFS = 7'h54;
	localparam logic [6:0] SELECT_OFS = 7'h55;
	localparam logic [6:0] DATA_LOCK_OFS = 7'h56;
	localparam logic [6:0] CFG_LOCK_OFS = 7'h57;
	localparam int CFG_BYTES = 68;

	// Array indices derived from the offsets
	localparam logic [6:0] POLICY_IDX = POLICY_OFS - CFG_BASE;
	localparam logic [6:0] USES_IDX = USES_OFS - CFG_BASE;
	localparam logic [6:0] DERIVE_IDX = DERIVE_OFS - CFG_BASE;
	localparam logic [6:0] MAP_IDX = MAP_OFS - CFG_BASE;
	localparam logic [6:0] USER_IDX = USER_OFS - CFG_BASE;
	localparam logic [6:0] SELECT_IDX = SELECT_OFS - CFG_BASE;
	localparam logic [6:0] DATA_LOCK_IDX = DATA_LOCK_OFS - CFG_BASE;
	localparam logic [6:0] CFG_LOCK_IDX = CFG_LOCK_OFS - CFG_BASE;

	// Reset values, the shut lock pattern and the derive counter limit
	localparam logic [7:0] LOCK_OPEN = 8'h55;
	localparam logic [7:0] LOCK_SHUT = 8'h00;
	localparam logic [7:0] USES_RST = 8'hFF;
	localparam logic [7:0] DERIVE_RST = 8'h00;
	localparam logic [7:0] DERIVE_MAX = 8'hFF;
	localparam logic [7:0] MAP_RST = 8'hFF;
	localparam logic [7:0] POLICY_RST = 8'h00;
	localparam logic [7:0] SPARE_RST = 8'h00;

	// Slot policy word field positions
	localparam int READ_KEY_LSB = 0;
	localparam int VERIFY_BIT = 4;
	localparam int LIMITED_BIT = 5;
	localparam int ENC_READ_BIT = 6;
	localparam int SECRET_BIT = 7;
	localparam int WRITE_KEY_LSB = 8;
	localparam int WPOL_LSB = 12;

	// Slot numbers with special limited-use handling
	localparam logic [3:0] COUNTED_SLOTS = 4'h8;
	localparam logic [3:0] MAP_SLOT = 4'hF;

	typedef enum logic [2:0] {
		OP_READ,
		OP_WRITE,
		OP_LOCK_CONFIG,
		OP_LOCK_DATA,
		OP_SPARE_UPDATE,
		OP_KEY_USE,
		OP_DERIVE_UPDATE
	} ssap_op_t;

	typedef enum logic [1:0] {
		ZONE_CONFIG,
		ZONE_OTP,
		ZONE_DATA
	} ssap_zone_t;

	typedef enum logic [1:0] {
		PUR_MAC_CHECK,
		PUR_DIGEST_FOR_CHECK,
		PUR_OTHER
	} ssap_purpose_t;

endpackage

/* ssap_policy.sv */
/*
 * Secure slot access policy: holds configuration bytes 20..87 (policy
 * words, use and derive counters, limited-use map, spare bytes, locks)
 * and answers permission requests for commands one cycle later.
 * Assumes a command parser outside that presents one request per cycle
 * and carries out the data movement and cryptography itself.
 */
// Design decision made here: the strobed register port.
// Operation
// - Remaining-use byte for keys 0-7, reset all ones
// - Derive counter byte for keys 0-7, reset zero
// - 128-bit limited-use map for slot 15
// - User byte changes only by spare update
// - Selector byte, spare update only, pause survivor
// - Data lock byte, 0x55 open, lock command
// - Locked: OTP by write, slots per policy
// - Unlocked data lock refuses OTP/data reads
// - Config changes only while config lock open; spare update, counters, map and data lock byte change after it shuts
// - Sixteen policy words, applied once data locked
// - Unlocked data: writes allowed, reads refused
// - Bits 0-3 read key; zero allows copy
// - Bit 4 restricts key to MAC check or digest for check
// - Bit 5 limited use, ignored slots 8-14
// - Bit 6 encrypted read, no input MAC
// - Bit 7 forbids clear and 4-byte access
// - Bits 8-11 write key identifier
// - Bits 12-15 write policy code
// - Decode write policy code top bits
// - Encrypted read without secret is prohibited
module ssap_policy
	import ssap_pkg::*;
(
	input logic clock,
	input logic rst_n,
	input logic [ssap_pkg::ADDR_W-1:0] bus_addr,
	input logic [ssap_pkg::DATA_W-1:0] bus_wr_data,
	input logic bus_wr,
	input logic bus_rd,
	output logic [ssap_pkg::DATA_W-1:0] bus_rd_data,
	input logic cmd_valid,
	input ssap_pkg::ssap_op_t cmd_op,
	input ssap_pkg::ssap_zone_t cmd_zone,
	input logic [3:0] cmd_slot,
	input logic cmd_long,
	input logic cmd_cipher,
	input logic cmd_mac_ok,
	input ssap_pkg::ssap_purpose_t cmd_purpose,
	input logic cmd_spare_sel,
	input logic [7:0] cmd_value,
	output logic resp_valid,
	output logic resp_ok,
	output logic resp_cipher,
	output logic [3:0] resp_key_id,
	output logic resp_copy_src,
	output logic resp_limited,
	output logic data_locked,
	output logic config_locked,
	output logic [7:0] pause_select
);
	import ssap_pkg::*;

	logic [7:0] mem_reg [CFG_BYTES];
	logic [15:0] pol;
	logic data_open, cfg_open;
	logic [6:0] pol_idx, uses_idx, der_idx, map_byte_idx, bus_idx;
	logic [127:0] use_map;
	logic map_any;
	logic [6:0] map_first;
	logic bus_in_range;
	logic dec_ok, dec_cipher, dec_copy, dec_limited;
	logic [3:0] dec_key;
	logic do_uses_dec, do_map_clr, do_der_inc, do_lock_cfg, do_lock_data, do_spare;
	logic slot_counted, slot_ignored;

	// Reset value of each held configuration byte
	function automatic logic [7:0] reset_byte(input int i);
		logic [7:0] v;
		v = POLICY_RST;
		if (i >= int'(USES_IDX) && i < int'(MAP_IDX))
		begin
			v = (i[0] == USES_IDX[0]) ? USES_RST : DERIVE_RST;
		end
		else if (i >= int'(MAP_IDX) && i < int'(USER_IDX))
		begin
			v = MAP_RST;
		end
		else if (i == int'(USER_IDX) || i == int'(SELECT_IDX))
		begin
			v = SPARE_RST;
		end
		else if (i >= int'(DATA_LOCK_IDX))
		begin
			v = LOCK_OPEN;
		end
		return v;
	endfunction

	// Lock states; any value other than the open pattern counts as locked
	assign data_open = (mem_reg[DATA_LOCK_IDX] == LOCK_OPEN);
	assign cfg_open = (mem_reg[CFG_LOCK_IDX] == LOCK_OPEN);

	// Byte indices of the addressed slot's fields
	assign pol_idx = POLICY_IDX + {2'b00, cmd_slot, 1'b0};
	assign uses_idx = USES_IDX + {3'b000, cmd_slot[2:0], 1'b0};
	assign der_idx = DERIVE_IDX + {3'b000, cmd_slot[2:0], 1'b0};
	assign pol = {mem_reg[pol_idx + 7'h01], mem_reg[pol_idx]};
	assign slot_counted = (cmd_slot < COUNTED_SLOTS);
	assign slot_ignored = !slot_counted && (cmd_slot != MAP_SLOT);
	assign bus_in_range = (bus_addr >= CFG_BASE) && (bus_addr <= CFG_LOCK_OFS);
	assign bus_idx = bus_addr - CFG_BASE;

	// Limited-use map for the last slot, lowest set bit is spent first
	always_comb
	begin
		map_any = 1'b0;
		map_first = 7'h00;
		for (int j = 0; j < 16; j++)
		begin
			use_map[j*8 +: 8] = mem_reg[int'(MAP_IDX) + j];
		end
		for (int b = 127; b >= 0; b--)
		begin
			if (use_map[b])
			begin
				map_any = 1'b1;
				map_first = 7'(b);
			end
		end
	end
	assign map_byte_idx = MAP_IDX + {3'b000, map_first[6:3]};

	// Permission decision for the request presented this cycle
	always_comb
	begin
		dec_ok = 1'b0;
		dec_cipher = 1'b0;
		dec_copy = 1'b0;
		dec_limited = 1'b0;
		dec_key = 4'h0;
		do_uses_dec = 1'b0;
		do_map_clr = 1'b0;
		do_der_inc = 1'b0;
		do_lock_cfg = 1'b0;
		do_lock_data = 1'b0;
		do_spare = 1'b0;
		case (cmd_op)
			OP_READ:
			begin
				dec_key = pol[READ_KEY_LSB +: 4];
				dec_copy = (pol[READ_KEY_LSB +: 4] == 4'h0);
				if (cmd_zone == ZONE_CONFIG)
				begin
					dec_ok = 1'b1;
				end
				else if (data_open)
				begin
					dec_ok = 1'b0;
				end
				else if (cmd_zone == ZONE_OTP)
				begin
					dec_ok = 1'b1;
				end
				else if (!pol[SECRET_BIT] && !pol[ENC_READ_BIT])
				begin
					dec_ok = 1'b1;
				end
				else if (pol[SECRET_BIT] && pol[ENC_READ_BIT])
				begin
					// Encrypted with the read key, no MAC, whole blocks only
					dec_cipher = 1'b1;
					dec_ok = cmd_long;
				end
				else
				begin
					// Secret without encryption, or the unsafe combination
					dec_ok = 1'b0;
				end
			end
			OP_WRITE:
			begin
				dec_key = pol[WRITE_KEY_LSB +: 4];
				if (cmd_zone == ZONE_CONFIG)
				begin
					dec_ok = cfg_open;
				end
				else if (data_open || cmd_zone == ZONE_OTP)
				begin
					dec_ok = 1'b1;
				end
				else if (pol[WPOL_LSB+1 +: 3] == 3'b000)
				begin
					dec_ok = cmd_long || !pol[SECRET_BIT];
				end
				else if (pol[WPOL_LSB+2])
				begin
					dec_cipher = 1'b1;
					dec_ok = cmd_long && cmd_cipher && cmd_mac_ok;
				end
				else
				begin
					dec_ok = 1'b0;
				end
			end
			OP_LOCK_CONFIG:
			begin
				dec_ok = cfg_open;
				do_lock_cfg = cfg_open;
			end
			OP_LOCK_DATA:
			begin
				// The data lock waits for a settled configuration
				dec_ok = data_open && !cfg_open;
				do_lock_data = data_open && !cfg_open;
			end
			OP_SPARE_UPDATE:
			begin
				dec_ok = 1'b1;
				do_spare = 1'b1;
			end
			OP_KEY_USE:
			begin
				dec_key = cmd_slot;
				dec_limited = !data_open && pol[LIMITED_BIT] && !slot_ignored;
				if (data_open)
				begin
					dec_ok = 1'b1;
				end
				else if (pol[VERIFY_BIT] && cmd_purpose == PUR_OTHER)
				begin
					dec_ok = 1'b0;
				end
				else if (dec_limited && slot_counted)
				begin
					dec_ok = (mem_reg[uses_idx] != 8'h00);
					do_uses_dec = (mem_reg[uses_idx] != 8'h00);
				end
				else if (dec_limited)
				begin
					dec_ok = map_any;
					do_map_clr = map_any;
				end
				else
				begin
					dec_ok = 1'b1;
				end
			end
			OP_DERIVE_UPDATE:
			begin
				dec_key = cmd_slot;
				dec_ok = !data_open && pol[WPOL_LSB+1] && (!pol[WPOL_LSB+3] || cmd_mac_ok);
				do_der_inc = dec_ok && slot_counted;
			end
			default:
			begin
				dec_ok = 1'b0;
			end
		endcase
	end

	// Configuration bytes; command effects follow the bus so they win a clash
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < CFG_BYTES; i++)
			begin
				mem_reg[i] <= reset_byte(i);
			end
		end
		else
		begin
			if (bus_wr && bus_in_range && bus_addr <= MAP_END && cfg_open)
			begin
				mem_reg[bus_idx] <= bus_wr_data;
			end
			if (cmd_valid && do_uses_dec)
			begin
				mem_reg[uses_idx] <= mem_reg[uses_idx] - 8'h01;
			end
			if (cmd_valid && do_der_inc && mem_reg[der_idx] != DERIVE_MAX)
			begin
				mem_reg[der_idx] <= mem_reg[der_idx] + 8'h01;
			end
			if (cmd_valid && do_map_clr)
			begin
				mem_reg[map_byte_idx][map_first[2:0]] <= 1'b0;
			end
			if (cmd_valid && do_spare)
			begin
				mem_reg[cmd_spare_sel ? SELECT_IDX : USER_IDX] <= cmd_value;
			end
			if (cmd_valid && do_lock_cfg)
			begin
				mem_reg[CFG_LOCK_IDX] <= LOCK_SHUT;
			end
			if (cmd_valid && do_lock_data)
			begin
				mem_reg[DATA_LOCK_IDX] <= LOCK_SHUT;
			end
		end
	end

	// Register read data, valid only in the cycle after the strobe
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			bus_rd_data <= 8'h00;
		end
		else
		begin
			bus_rd_data <= (bus_rd && bus_in_range) ? mem_reg[bus_idx] : 8'h00;
		end
	end

	// Answer to the request, one cycle after it is presented
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			resp_valid <= 1'b0;
			resp_ok <= 1'b0;
			resp_cipher <= 1'b0;
			resp_key_id <= 4'h0;
			resp_copy_src <= 1'b0;
			resp_limited <= 1'b0;
		end
		else
		begin
			resp_valid <= cmd_valid;
			resp_ok <= cmd_valid && dec_ok;
			resp_cipher <= cmd_valid && dec_cipher;
			resp_key_id <= cmd_valid ? dec_key : 4'h0;
			resp_copy_src <= cmd_valid && dec_copy;
			resp_limited <= cmd_valid && dec_limited;
		end
	end

	// Status outputs lag the held bytes by one cycle to stay registered
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			data_locked <= 1'b0;
			config_locked <= 1'b0;
			pause_select <= 8'h00;
		end
		else
		begin
			data_locked <= !data_open;
			config_locked <= !cfg_open;
			pause_select <= mem_reg[SELECT_IDX];
		end
	end

	// Checks
	a_read_unlocked: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_valid && cmd_op == OP_READ && cmd_zone != ZONE_CONFIG && data_open
		|=> resp_valid && !resp_ok)
		else $error("read of otp or data allowed while unlocked");

	a_write_unlocked: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_valid && cmd_op == OP_WRITE && cmd_zone == ZONE_DATA && data_open
		|=> resp_ok)
		else $error("data write refused while unlocked");

	a_bus_write_locked: assert property (@(posedge clock) disable iff (!rst_n)
		bus_wr && !cfg_open && bus_in_range && !cmd_valid
		|=> mem_reg[$past(bus_idx)] == $past(mem_reg[bus_idx]))
		else $error("bus write changed a byte with config locked");

	a_lock_config: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_valid && cmd_op == OP_LOCK_CONFIG && cfg_open
		|=> resp_ok ##1 config_locked)
		else $error("config lock command did not lock");

	a_unsafe_read: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_valid && cmd_op == OP_READ && cmd_zone == ZONE_DATA && !data_open
		&& !pol[SECRET_BIT] && pol[ENC_READ_BIT] |=> !resp_ok)
		else $error("prohibited read combination allowed");

	a_secret_short: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_valid && cmd_zone == ZONE_DATA && !data_open && !cmd_long
		&& pol[SECRET_BIT] && (cmd_op == OP_READ || cmd_op == OP_WRITE) |=> !resp_ok)
		else $error("short access to a secret slot allowed");

	a_use_count: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_valid && do_uses_dec && !bus_wr
		|=> mem_reg[$past(uses_idx)] == $past(mem_reg[uses_idx]) - 8'h01 && resp_ok)
		else $error("remaining use count not decremented");

	a_verify_only: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_valid && cmd_op == OP_KEY_USE && !data_open && pol[VERIFY_BIT]
		&& cmd_purpose == PUR_OTHER |=> resp_valid && !resp_ok)
		else $error("verify-only key used by another command");

	a_cipher_key: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_valid && cmd_op == OP_READ && cmd_zone == ZONE_DATA && !data_open
		&& pol[SECRET_BIT] && pol[ENC_READ_BIT] && cmd_long
		|=> resp_ok && resp_cipher && resp_key_id == $past(pol[READ_KEY_LSB +: 4]))
		else $error("encrypted read lacks the read key");

	c_lock_data: cover property (@(posedge clock) disable iff (!rst_n)
		cmd_valid && do_lock_data ##1 resp_ok ##1 data_locked);

	c_map_spent: cover property (@(posedge clock) disable iff (!rst_n)
		cmd_valid && do_map_clr);

	c_enc_write: cover property (@(posedge clock) disable iff (!rst_n)
		cmd_valid && cmd_op == OP_WRITE && dec_cipher && dec_ok);

	c_spare_select: cover property (@(posedge clock) disable iff (!rst_n)
		cmd_valid && do_spare && cmd_spare_sel ##2 pause_select == $past(cmd_value, 2));

endmodule // ssap_policy

/* ssap_host_model.sv */
/*
 * Host side model for the slot access policy block: register bus master
 * and command parser stand-in, driven through its tasks by the bench.
 * Assumes the block answers reads and commands exactly one cycle later.
 */
module ssap_host_model
	import ssap_pkg::*;
(
	input logic clock,
	output logic [ssap_pkg::ADDR_W-1:0] bus_addr,
	output logic [ssap_pkg::DATA_W-1:0] bus_wr_data,
	output logic bus_wr,
	output logic bus_rd,
	input logic [ssap_pkg::DATA_W-1:0] bus_rd_data,
	output logic cmd_valid,
	output ssap_pkg::ssap_op_t cmd_op,
	output ssap_pkg::ssap_zone_t cmd_zone,
	output logic [3:0] cmd_slot,
	output logic cmd_long,
	output logic cmd_cipher,
	output logic cmd_mac_ok,
	output ssap_pkg::ssap_purpose_t cmd_purpose,
	output logic cmd_spare_sel,
	output logic [7:0] cmd_value
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus at time zero
	initial
	begin
		{bus_addr, bus_wr_data, bus_wr, bus_rd, cmd_valid} = '0;
		{cmd_slot, cmd_long, cmd_cipher, cmd_mac_ok, cmd_spare_sel, cmd_value} = '0;
		cmd_op = OP_READ;
		cmd_zone = ZONE_CONFIG;
		cmd_purpose = PUR_OTHER;
	end

	// Released lines show the inverse so a stale value is never read
	task automatic bus_write(input logic [6:0] a, input logic [7:0] d);
		@(posedge clock);
		bus_addr <= a;
		bus_wr_data <= d;
		bus_wr <= 1'b1;
		@(posedge clock);
		bus_wr <= 1'b0;
		bus_addr <= ~a;
		bus_wr_data <= ~d;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic bus_read(input logic [6:0] a, output logic [7:0] d);
		@(posedge clock);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clock);
		bus_rd <= 1'b0;
		bus_addr <= ~a;
		#1;
		d = bus_rd_data;
	endtask

	// The secret bit is added whenever encrypted read or a non-open write code asks for it
	task automatic set_policy(input logic [3:0] s, input logic [15:0] w);
		logic [15:0] v;
		v = w | ((w[6] || w[15:13] != 3'h0) ? 16'h0080 : 16'h0000);
		bus_write(POLICY_OFS + 7'(2 * s), v[7:0]);
		bus_write(POLICY_OFS + 7'(2 * s + 1), v[15:8]);
	endtask

	// One request; returns while the answer stands; f holds long, cipher, MAC ok
	task automatic issue(input ssap_op_t op, input ssap_zone_t z, input logic [3:0] s,
		input logic [2:0] f, input ssap_purpose_t p, input logic [7:0] v);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_zone <= z;
		cmd_slot <= s;
		{cmd_long, cmd_cipher, cmd_mac_ok} <= f;
		cmd_purpose <= p;
		cmd_spare_sel <= s[0];
		cmd_value <= v;
		@(posedge clock);
		cmd_valid <= 1'b0;
		cmd_slot <= ~s;
		cmd_value <= ~v;
		#1;
	endtask
endmodule // ssap_host_model

/* ssap_policy_test.sv */
/*
 * Self-checking bench for the slot access policy block: reset values,
 * unlocked and locked access decisions, lock commands and key counters.
 * Assumes the host model drives every block input except clock and rst_n, which the bench drives.
 */
module ssap_policy_test;
	timeunit 1ns;
	timeprecision 100ps;
	import ssap_pkg::*;

	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] bus_addr;
	logic [7:0] bus_wr_data, bus_rd_data, cmd_value, pause_select;
	logic bus_wr, bus_rd, cmd_valid, cmd_long, cmd_cipher, cmd_mac_ok, cmd_spare_sel;
	ssap_op_t cmd_op;
	ssap_zone_t cmd_zone;
	ssap_purpose_t cmd_purpose;
	logic [3:0] cmd_slot, resp_key_id;
	logic resp_valid, resp_ok, resp_cipher, resp_copy_src, resp_limited;
	logic data_locked, config_locked;
	int n_errors = 0;
	int compares = 0;

	always #2.5 clock = ~clock;

	ssap_host_model host_u (.clock, .bus_addr, .bus_wr_data, .bus_wr, .bus_rd, .bus_rd_data,
		.cmd_valid, .cmd_op, .cmd_zone, .cmd_slot, .cmd_long, .cmd_cipher, .cmd_mac_ok,
		.cmd_purpose, .cmd_spare_sel, .cmd_value);
	ssap_policy dut_u (.clock, .rst_n, .bus_addr, .bus_wr_data, .bus_wr, .bus_rd, .bus_rd_data,
		.cmd_valid, .cmd_op, .cmd_zone, .cmd_slot, .cmd_long, .cmd_cipher, .cmd_mac_ok,
		.cmd_purpose, .cmd_spare_sel, .cmd_value, .resp_valid, .resp_ok, .resp_cipher,
		.resp_key_id, .resp_copy_src, .resp_limited, .data_locked, .config_locked, .pause_select);

	task automatic complete_run();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rb(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		host_u.bus_read(a, d);
		chk($sformatf("byte %h", a), d, e);
	endtask

	task automatic ck(input ssap_op_t op, input ssap_zone_t z, input logic [3:0] s,
		input logic [2:0] f, input ssap_purpose_t p, input logic e);
		host_u.issue(op, z, s, f, p, 8'h00);
		chk($sformatf("ok %s slot %h", op.name(), s), {resp_valid, resp_ok}, {1'b1, e});
	endtask

	// Lock state outputs lag the lock byte by one cycle
	task automatic settle();
		@(posedge clock);
		#1;
	endtask

	// Reset values and unmapped reads; entries are address then data
	task automatic t_reset();
		logic [15:0] t[13] = '{16'h1400, 16'h34FF, 16'h3500, 16'h42FF, 16'h4300, 16'h44FF,
			16'h53FF, 16'h5400, 16'h5500, 16'h5655, 16'h5755, 16'h0A00, 16'h5A00};
		foreach (t[i])
			rb(t[i][14:8], t[i][7:0]);
		chk("locks", {data_locked, config_locked}, 16'h0000);
	endtask

	// Policies go in while open; unlocked slots ignore them
	task automatic t_unlocked();
		logic [19:0] pol[7] = '{20'h0_0000, 20'h1_00C2, 20'h2_4580, 20'h3_20A1,
			20'h4_0093, 20'h9_0020, 20'hF_00A0};
		foreach (pol[i])
			host_u.set_policy(pol[i][19:16], pol[i][15:0]);
		// Slot 5 gets the unsafe encrypted-read-without-secret word on purpose
		host_u.bus_write(7'h1E, 8'h40);
		rb(7'h18, 8'h80);
		rb(7'h19, 8'h45);
		ck(OP_READ, ZONE_DATA, 4'h0, 3'b100, PUR_OTHER, 1'b0);
		ck(OP_READ, ZONE_OTP, 4'h0, 3'b100, PUR_OTHER, 1'b0);
		ck(OP_WRITE, ZONE_DATA, 4'h2, 3'b000, PUR_OTHER, 1'b1);
		host_u.bus_write(USER_OFS, 8'h5A);
		host_u.bus_write(DATA_LOCK_OFS, 8'h00);
		rb(USER_OFS, 8'h00);
		rb(DATA_LOCK_OFS, 8'h55);
		host_u.issue(OP_SPARE_UPDATE, ZONE_CONFIG, 4'h1, 3'b000, PUR_OTHER, 8'h3C);
		chk("spare ok", resp_ok, 1'b1);
		rb(SELECT_OFS, 8'h3C);
		chk("pause_select", pause_select, 8'h3C);
	endtask

	// Lock commands, refused config writes after locking
	task automatic t_lock();
		ck(OP_LOCK_CONFIG, ZONE_CONFIG, 4'h0, 3'b000, PUR_OTHER, 1'b1);
		settle();
		chk("config_locked", config_locked, 1'b1);
		rb(CFG_LOCK_OFS, 8'h00);
		ck(OP_LOCK_CONFIG, ZONE_CONFIG, 4'h0, 3'b000, PUR_OTHER, 1'b0);
		host_u.bus_write(7'h14, 8'h77);
		host_u.bus_write(MAP_OFS, 8'h00);
		rb(7'h14, 8'h00);
		rb(MAP_OFS, 8'hFF);
		ck(OP_WRITE, ZONE_CONFIG, 4'h0, 3'b100, PUR_OTHER, 1'b0);
		ck(OP_LOCK_DATA, ZONE_CONFIG, 4'h0, 3'b000, PUR_OTHER, 1'b1);
		settle();
		chk("data_locked", data_locked, 1'b1);
		rb(DATA_LOCK_OFS, 8'h00);
		host_u.issue(OP_SPARE_UPDATE, ZONE_CONFIG, 4'h0, 3'b000, PUR_OTHER, 8'h11);
		rb(USER_OFS, 8'h11);
	endtask

	// Locked data zone reads and writes decided by each policy word
	task automatic t_locked_rw();
		ck(OP_READ, ZONE_DATA, 4'h0, 3'b000, PUR_OTHER, 1'b1);
		chk("copy_src", resp_copy_src, 1'b1);
		ck(OP_READ, ZONE_DATA, 4'h1, 3'b000, PUR_OTHER, 1'b0);
		ck(OP_READ, ZONE_DATA, 4'h1, 3'b100, PUR_OTHER, 1'b1);
		chk("read key", {resp_cipher, resp_copy_src, resp_key_id}, 16'h0022);
		ck(OP_READ, ZONE_DATA, 4'h3, 3'b100, PUR_OTHER, 1'b0);
		ck(OP_READ, ZONE_DATA, 4'h5, 3'b100, PUR_OTHER, 1'b0);
		ck(OP_READ, ZONE_OTP, 4'h0, 3'b100, PUR_OTHER, 1'b1);
		ck(OP_WRITE, ZONE_OTP, 4'h0, 3'b100, PUR_OTHER, 1'b1);
		ck(OP_WRITE, ZONE_DATA, 4'h0, 3'b000, PUR_OTHER, 1'b1);
		ck(OP_WRITE, ZONE_DATA, 4'h2, 3'b100, PUR_OTHER, 1'b0);
		ck(OP_WRITE, ZONE_DATA, 4'h2, 3'b111, PUR_OTHER, 1'b1);
		chk("write key", resp_key_id, 4'h5);
		ck(OP_WRITE, ZONE_DATA, 4'h2, 3'b011, PUR_OTHER, 1'b0);
		ck(OP_WRITE, ZONE_DATA, 4'h3, 3'b111, PUR_OTHER, 1'b0);
	endtask

	// Limited-use counting, verify-only keys and derive counting
	task automatic t_keys();
		ck(OP_KEY_USE, ZONE_DATA, 4'h3, 3'b000, PUR_OTHER, 1'b1);
		chk("limited 3", resp_limited, 1'b1);
		rb(7'h3A, 8'hFE);
		ck(OP_KEY_USE, ZONE_DATA, 4'h9, 3'b000, PUR_OTHER, 1'b1);
		chk("limited 9", resp_limited, 1'b0);
		ck(OP_KEY_USE, ZONE_DATA, 4'hF, 3'b000, PUR_OTHER, 1'b1);
		chk("limited 15", resp_limited, 1'b1);
		rb(MAP_OFS, 8'hFE);
		ck(OP_KEY_USE, ZONE_DATA, 4'h4, 3'b000, PUR_OTHER, 1'b0);
		ck(OP_KEY_USE, ZONE_DATA, 4'h4, 3'b000, PUR_MAC_CHECK, 1'b1);
		ck(OP_KEY_USE, ZONE_DATA, 4'h4, 3'b000, PUR_DIGEST_FOR_CHECK, 1'b1);
		ck(OP_DERIVE_UPDATE, ZONE_DATA, 4'h3, 3'b000, PUR_OTHER, 1'b1);
		rb(7'h3B, 8'h01);
		ck(OP_DERIVE_UPDATE, ZONE_DATA, 4'h0, 3'b000, PUR_OTHER, 1'b0);
	endtask

	// Guard against a hang
	initial
	begin
		repeat (20000) @(posedge clock);
		n_errors++;
		complete_run();
	end

	initial
	begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_unlocked();
		t_lock();
		t_locked_rw();
		t_keys();
		complete_run();
	end
endmodule // ssap_policy_test
